/* File: logic/enclave_pkg.sv */
// constants for the enclave page block and create leaf engine
package enclave_pkg;
	localparam logic [7:0] ADDR_RESULT = 8'h00;
	localparam logic [7:0] ADDR_OP2 = 8'h04;
	localparam logic [7:0] ADDR_OP3 = 8'h08;
	localparam logic [7:0] ADDR_OP3_HI = 8'h0C;
	localparam logic [7:0] ADDR_CTRL = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_SEG_LIMIT = 8'h18;
	localparam logic [7:0] ADDR_CONC = 8'h1C;
	localparam logic [7:0] ADDR_PI_SRC = 8'h20;
	localparam logic [7:0] ADDR_PI_SECURITY_INFO_RECORD = 8'h24;
	localparam logic [7:0] ADDR_PI_CTRL = 8'h28;
	localparam logic [7:0] ADDR_PI_LIN = 8'h2C;
	localparam logic [7:0] ADDR_SECURITY_INFO_RECORD_TYPE = 8'h30;
	localparam logic [7:0] ADDR_SRC_SIZE = 8'h34;
	localparam logic [7:0] ADDR_SRC_BASE = 8'h38;
	localparam logic [7:0] ADDR_SRC_XFM = 8'h3C;
	localparam logic [7:0] ADDR_SRC_FRAME = 8'h40;
	localparam logic [7:0] ADDR_MAP_INDEX = 8'h44;
	localparam logic [7:0] ADDR_MAP_DATA = 8'h48;
	localparam logic [31:0] LEAF_BLOCK = 32'h0000_0009;
	localparam logic [31:0] LEAF_CREATE = 32'h0000_0000;
	localparam logic [31:0] RES_OK = 32'h0000_0000;
	localparam logic [31:0] ALREADY_BLOCKED_CODE = 32'h0000_0001;
	localparam logic [31:0] EPOCH_LOCKED_CODE = 32'h0000_0002;
	localparam logic [31:0] NOT_BLOCKABLE_CODE = 32'h0000_0003;
	localparam logic [31:0] PAGE_INVALID_CODE = 32'h0000_0004;
	localparam logic [31:0] LOCK_FAIL_CODE = 32'h0000_0005;
	localparam logic [15:0] FAULT_ERR_CODE = 16'h0000;
	localparam logic [2:0] CONTROL_PAGE_TYPE = 3'h0;
	localparam logic [2:0] THREAD_CONTROL_TYPE = 3'h1;
	localparam logic [2:0] REGULAR_PAGE_TYPE = 3'h2;
	localparam logic [2:0] TRIMMED_PAGE_TYPE = 3'h4;
	localparam int PAGE_SHIFT = 12;
	localparam int RECORD_ALIGN = 5;
	localparam int SECURITY_INFO_RECORD_ALIGN = 6;
	localparam int CANON_MSB = 15;
	localparam logic [31:0] MIN_ENCLAVE_SIZE = 32'h0000_2000;
	localparam logic [31:0] GPR_AREA_BYTES = 32'h0000_00B8;
	localparam logic [31:0] FEATURE_AREA_BYTES = 32'h0000_0100;
	localparam int ENTRY_W = 69;
	localparam int ENT_VALID = 0;
	localparam int ENT_BLOCKED = 1;
	localparam int ENT_TYPE_LO = 2;
	localparam int ENT_BASE_LO = 5;
	localparam int ENT_SIZE_LO = 37;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ZF = 2;
	localparam int ST_CF = 3;
	localparam int ST_GP = 8;
	localparam int ST_PF = 9;
	typedef enum logic [2:0] {
		LS_IDLE = 3'b000,
		LS_FETCH = 3'b001,
		LS_LATCH = 3'b011,
		LS_DECIDE = 3'b010,
		LS_FINISH = 3'b110
	} leaf_state_e;
endpackage : enclave_pkg

/* File: logic/page_map_mem.sv */
// page cache map entries with a registered read port
`timescale 1ns/100ps
module page_map_mem #(
	parameter int WIDTH = 69,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data
);
	logic [WIDTH-1:0] entry_reg [DEPTH];

	// every entry clears so no page looks valid after reset
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_entry
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n)
					entry_reg[i] <= '0;
				else if (clk_en && wr_en && wr_addr == AW'(i))
					entry_reg[i] <= wr_data;
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			rd_data <= '0;
		else if (clk_en)
			rd_data <= entry_reg[rd_addr];
	end
endmodule : page_map_mem

/* File: logic/save_frame_calc.sv */
// save frame size needed for a given extended feature mask
`timescale 1ns/100ps
module save_frame_calc
	import enclave_pkg::*;
#(
	parameter int MASK_W = 32
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [MASK_W-1:0] feature_mask,
	output logic [31:0] save_bytes
);
	logic [31:0] partial [MASK_W+1];

	assign partial[0] = GPR_AREA_BYTES;
	genvar i;
	generate
		for (i = 0; i < MASK_W; i++) begin : g_feat
			assign partial[i+1] = partial[i] + (feature_mask[i] ? FEATURE_AREA_BYTES : 32'h0);
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			save_bytes <= '0;
		else if (clk_en)
			save_bytes <= partial[MASK_W];
	end
endmodule : save_frame_calc

/* File: logic/enclave_leaf_engine.sv */
// apb reached engine for the block page and create control page leaves
`timescale 1ns/100ps
// Operation
// - leaf 09H blocks a page, privilege 0 only, status in result register
// - block status: 0 success, already blocked, epoch locked, not blockable, invalid, lock
// - prior blocked state kept in a 64-bit temporary and tested
// - already blocked sets carry and code; otherwise blocked bit set to 1
// - only valid thread control, regular or trimmed pages can be blocked
// - zero flag set when structure in use or page invalid, else cleared
// - carry flag set when already blocked or not blockable, else cleared
// - every block completion without a fault clears parity, aux carry, overflow and sign
// - limit, misalignment or resource in use gives protection fault, code 0
// - operand outside protected cache or access fault gives page fault
// - non-canonical address in 64-bit mode gives protection fault, code 0
// - leaf 00H creates a control structure page in the protected cache
// - create copies source structure into page, sets fields, marks it valid
// - created control structure contents never readable by software
// - page info record gives source and security info; control field must be zero
// - create faults on target in use, already valid, outside cache, misaligned
// - needed save frame bigger than declared frame gives protection fault, code 0
// - records read as non-enclave, destination written with enclave access
module enclave_leaf_engine
	import enclave_pkg::*;
#(
	parameter logic [31:0] CACHE_BASE = 32'h8000_0000,
	parameter int CACHE_PAGES = 16,
	parameter int AW = 4
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	localparam logic [32:0] CACHE_END = {1'b0, CACHE_BASE} + 33'(CACHE_PAGES << PAGE_SHIFT);

	leaf_state_e state_reg, state_next;
	logic [31:0] result_reg, op2_reg, op3_reg, op3_hi_reg, seg_limit_reg;
	logic [31:0] pi_src_reg, pi_security_info_record_reg, pi_ctrl_reg, pi_lin_reg;
	logic [31:0] src_size_reg, src_base_reg, src_xfm_reg, src_frame_reg;
	logic [2:0] security_info_record_type_reg;
	logic [4:0] conc_reg;
	logic [1:0] priv_reg;
	logic mode64_reg, done_reg, gp_reg, pf_reg;
	logic zf_reg, cf_reg, par_reg, aux_reg, ovf_reg, sgn_reg;
	logic [AW-1:0] map_index_reg;
	logic [63:0] prior_block_state_reg;
	logic [ENTRY_W-1:0] entry_reg;

	// apb decode
	wire access = psel & penable;
	wire complete = access & pready;
	wire wr_fire = complete & pwrite;
	wire hit_result = paddr == ADDR_RESULT;
	wire hit_op2 = paddr == ADDR_OP2;
	wire hit_op3 = paddr == ADDR_OP3;
	wire hit_op3_hi = paddr == ADDR_OP3_HI;
	wire hit_ctrl = paddr == ADDR_CTRL;
	wire hit_status = paddr == ADDR_STATUS;
	wire hit_seg = paddr == ADDR_SEG_LIMIT;
	wire hit_conc = paddr == ADDR_CONC;
	wire hit_pi_src = paddr == ADDR_PI_SRC;
	wire hit_pi_sec = paddr == ADDR_PI_SECURITY_INFO_RECORD;
	wire hit_pi_ctrl = paddr == ADDR_PI_CTRL;
	wire hit_pi_lin = paddr == ADDR_PI_LIN;
	wire hit_sec_type = paddr == ADDR_SECURITY_INFO_RECORD_TYPE;
	wire hit_src_size = paddr == ADDR_SRC_SIZE;
	wire hit_src_base = paddr == ADDR_SRC_BASE;
	wire hit_src_xfm = paddr == ADDR_SRC_XFM;
	wire hit_src_frame = paddr == ADDR_SRC_FRAME;
	wire hit_map_index = paddr == ADDR_MAP_INDEX;
	wire hit_map_data = paddr == ADDR_MAP_DATA;
	wire hit_any = hit_result | hit_op2 | hit_op3 | hit_op3_hi | hit_ctrl | hit_status
		| hit_seg | hit_conc | hit_pi_src | hit_pi_sec | hit_pi_ctrl | hit_pi_lin
		| hit_sec_type | hit_src_size | hit_src_base | hit_src_xfm | hit_src_frame
		| hit_map_index | hit_map_data;
	wire idle = state_reg == LS_IDLE;
	// operands may only change while no leaf runs
	wire wr_ok = wr_fire & idle;
	wire start = wr_ok & hit_ctrl & pwdata[0];
	wire sw_map_we = wr_ok & hit_map_data;

	// page map and save frame helpers
	logic [ENTRY_W-1:0] map_rd_data;
	logic [31:0] save_bytes;
	wire [31:0] page_off = op3_reg - CACHE_BASE;
	wire [AW-1:0] page_idx = page_off[PAGE_SHIFT+AW-1:PAGE_SHIFT];
	wire [AW-1:0] map_rd_addr = idle ? map_index_reg : page_idx;
	wire leaf_we;
	wire [ENTRY_W-1:0] leaf_wdata;
	wire [AW-1:0] map_wr_addr = idle ? map_index_reg : page_idx;
	wire [ENTRY_W-1:0] sw_wdata = {{(ENTRY_W-5){1'b0}}, pwdata[4:0]};
	wire [ENTRY_W-1:0] map_wr_data = idle ? sw_wdata : leaf_wdata;

	page_map_mem #(
		.WIDTH(ENTRY_W),
		.DEPTH(CACHE_PAGES),
		.AW(AW)
	) u_map (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.rd_addr(map_rd_addr),
		.rd_data(map_rd_data),
		.wr_en(sw_map_we | leaf_we),
		.wr_addr(map_wr_addr),
		.wr_data(map_wr_data)
	);

	save_frame_calc #(
		.MASK_W(32)
	) u_save (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.feature_mask(src_xfm_reg),
		.save_bytes(save_bytes)
	);

	// operand checks
	wire priv_bad = priv_reg != 2'b00;
	wire seg_bad3 = op3_reg > seg_limit_reg;
	wire seg_bad2 = op2_reg > seg_limit_reg;
	wire mis3 = |op3_reg[PAGE_SHIFT-1:0];
	wire mis2 = |op2_reg[RECORD_ALIGN-1:0];
	wire canon = &op3_hi_reg[31:CANON_MSB] | ~|op3_hi_reg[31:CANON_MSB];
	wire non_canon = mode64_reg & ~canon;
	wire in_cache = {1'b0, op3_reg} >= {1'b0, CACHE_BASE} && {1'b0, op3_reg} < CACHE_END;
	wire epoch_locked = conc_reg[0];
	wire lock_fail = conc_reg[1];
	wire res_in_use = conc_reg[2];
	wire acc_fault = conc_reg[3];
	wire ent_valid = entry_reg[ENT_VALID];
	wire [2:0] ent_type = entry_reg[ENT_TYPE_LO+:3];
	wire blockable = ent_type == THREAD_CONTROL_TYPE || ent_type == REGULAR_PAGE_TYPE
		|| ent_type == TRIMMED_PAGE_TYPE;
	wire src_mis = |pi_src_reg[PAGE_SHIFT-1:0] | |pi_security_info_record_reg[SECURITY_INFO_RECORD_ALIGN-1:0];
	wire pi_bad = pi_lin_reg != 32'h0 || pi_ctrl_reg != 32'h0;
	wire type_bad = security_info_record_type_reg != CONTROL_PAGE_TYPE;
	wire [43:0] frame_bytes = {src_frame_reg, 12'h000};
	wire save_big = {12'h000, save_bytes} > frame_bytes;
	wire size_bad = src_size_reg < MIN_ENCLAVE_SIZE
		|| (src_size_reg & (src_size_reg - 32'h1)) != 32'h0;
	wire base_bad = (src_base_reg & (src_size_reg - 32'h1)) != 32'h0;
	wire xfm_bad = src_xfm_reg[1:0] != 2'b11;

	logic gp_n, pf_n, zf_n, cf_n, upd_n, we_n;
	logic [31:0] code_n;
	logic [ENTRY_W-1:0] wdata_n;

	always_comb begin
		gp_n = 1'b0;
		pf_n = 1'b0;
		zf_n = 1'b0;
		cf_n = 1'b0;
		upd_n = 1'b0;
		we_n = 1'b0;
		code_n = result_reg;
		wdata_n = entry_reg;
		if (result_reg == LEAF_BLOCK) begin
			if (priv_bad || seg_bad3 || mis3 || non_canon || res_in_use) begin
				gp_n = 1'b1;
			end else if (!in_cache || acc_fault) begin
				pf_n = 1'b1;
			end else begin
				upd_n = 1'b1;
				code_n = RES_OK;
				if (epoch_locked) begin
					code_n = EPOCH_LOCKED_CODE;
					zf_n = 1'b1;
				end else if (lock_fail) begin
					code_n = LOCK_FAIL_CODE;
					zf_n = 1'b1;
				end else if (!ent_valid) begin
					code_n = PAGE_INVALID_CODE;
					zf_n = 1'b1;
				end else if (!blockable) begin
					code_n = NOT_BLOCKABLE_CODE;
					cf_n = 1'b1;
				end else if (prior_block_state_reg[0]) begin
					code_n = ALREADY_BLOCKED_CODE;
					cf_n = 1'b1;
				end else begin
					we_n = 1'b1;
					wdata_n[ENT_BLOCKED] = 1'b1;
				end
			end
		end else if (result_reg == LEAF_CREATE) begin
			if (priv_bad || seg_bad2 || seg_bad3 || mis2 || mis3 || non_canon) begin
				gp_n = 1'b1;
			end else if (!in_cache) begin
				pf_n = 1'b1;
			end else if (src_mis || pi_bad || type_bad || res_in_use) begin
				gp_n = 1'b1;
			end else if (ent_valid) begin
				pf_n = 1'b1;
			end else if (xfm_bad || save_big || size_bad || base_bad) begin
				gp_n = 1'b1;
			end else if (acc_fault) begin
				pf_n = 1'b1;
			end else begin
				we_n = 1'b1;
				// copied structure lands only inside the entry, never on the bus
				wdata_n = {src_size_reg, src_base_reg, CONTROL_PAGE_TYPE, 1'b0, 1'b1};
			end
		end else begin
			// unknown leaf codes are refused like a bad operand
			gp_n = 1'b1;
		end
	end

	// single cycle write after every check has passed
	assign leaf_we = state_reg == LS_DECIDE && we_n;
	assign leaf_wdata = wdata_n;

	always_comb begin
		case (state_reg)
			LS_IDLE: state_next = start ? LS_FETCH : LS_IDLE;
			LS_FETCH: state_next = LS_LATCH;
			LS_LATCH: state_next = LS_DECIDE;
			LS_DECIDE: state_next = LS_FINISH;
			LS_FINISH: state_next = LS_IDLE;
			default: state_next = LS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= LS_IDLE;
			entry_reg <= '0;
			prior_block_state_reg <= '0;
		end else if (clk_en) begin
			state_reg <= state_next;
			if (state_reg == LS_LATCH) begin
				entry_reg <= map_rd_data;
				prior_block_state_reg <= {63'h0, map_rd_data[ENT_BLOCKED]};
			end
		end
	end

	// outcome of a leaf
	wire decide = state_reg == LS_DECIDE;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_reg <= 1'b0;
			gp_reg <= 1'b0;
			pf_reg <= 1'b0;
			zf_reg <= 1'b0;
			cf_reg <= 1'b0;
			par_reg <= 1'b0;
			aux_reg <= 1'b0;
			ovf_reg <= 1'b0;
			sgn_reg <= 1'b0;
		end else if (clk_en) begin
			if (start) begin
				done_reg <= 1'b0;
				gp_reg <= 1'b0;
				pf_reg <= 1'b0;
			end else if (state_reg == LS_FINISH) begin
				done_reg <= 1'b1;
			end
			if (decide) begin
				gp_reg <= gp_n;
				pf_reg <= pf_n;
			end
			if (decide && upd_n) begin
				zf_reg <= zf_n;
				cf_reg <= cf_n;
				par_reg <= 1'b0;
				aux_reg <= 1'b0;
				ovf_reg <= 1'b0;
				sgn_reg <= 1'b0;
			end
		end
	end

	// software registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_reg <= '0;
			op2_reg <= '0;
			op3_reg <= '0;
			op3_hi_reg <= '0;
			seg_limit_reg <= '1;
			conc_reg <= '0;
			pi_src_reg <= '0;
			pi_security_info_record_reg <= '0;
			pi_ctrl_reg <= '0;
			pi_lin_reg <= '0;
			security_info_record_type_reg <= '0;
			src_size_reg <= '0;
			src_base_reg <= '0;
			src_xfm_reg <= '0;
			src_frame_reg <= '0;
			map_index_reg <= '0;
			priv_reg <= '0;
			mode64_reg <= 1'b0;
		end else if (clk_en) begin
			if (decide && upd_n)
				result_reg <= code_n;
			else if (wr_ok && hit_result)
				result_reg <= pwdata;
			if (wr_ok && hit_op2) op2_reg <= pwdata;
			if (wr_ok && hit_op3) op3_reg <= pwdata;
			if (wr_ok && hit_op3_hi) op3_hi_reg <= pwdata;
			if (wr_ok && hit_seg) seg_limit_reg <= pwdata;
			if (wr_ok && hit_conc) conc_reg <= pwdata[4:0];
			if (wr_ok && hit_pi_src) pi_src_reg <= pwdata;
			if (wr_ok && hit_pi_sec) pi_security_info_record_reg <= pwdata;
			if (wr_ok && hit_pi_ctrl) pi_ctrl_reg <= pwdata;
			if (wr_ok && hit_pi_lin) pi_lin_reg <= pwdata;
			if (wr_ok && hit_sec_type) security_info_record_type_reg <= pwdata[2:0];
			if (wr_ok && hit_src_size) src_size_reg <= pwdata;
			if (wr_ok && hit_src_base) src_base_reg <= pwdata;
			if (wr_ok && hit_src_xfm) src_xfm_reg <= pwdata;
			if (wr_ok && hit_src_frame) src_frame_reg <= pwdata;
			if (wr_ok && hit_map_index) map_index_reg <= pwdata[AW-1:0];
			if (wr_ok && hit_ctrl) begin
				priv_reg <= pwdata[2:1];
				mode64_reg <= pwdata[3];
			end
		end
	end

	// read mux; the map window shows only the valid, blocked and type bits
	wire [31:0] status_word = {FAULT_ERR_CODE, 6'h00, pf_reg, gp_reg, sgn_reg, ovf_reg,
		aux_reg, par_reg, cf_reg, zf_reg, done_reg, ~idle};
	wire [31:0] ctrl_word = {28'h0, mode64_reg, priv_reg, 1'b0};
	wire [31:0] rd_word =
		hit_result ? result_reg : hit_op2 ? op2_reg :
		hit_op3 ? op3_reg : hit_op3_hi ? op3_hi_reg :
		hit_ctrl ? ctrl_word : hit_status ? status_word :
		hit_seg ? seg_limit_reg : hit_conc ? {27'h0, conc_reg} :
		hit_pi_src ? pi_src_reg : hit_pi_sec ? pi_security_info_record_reg :
		hit_pi_ctrl ? pi_ctrl_reg : hit_pi_lin ? pi_lin_reg :
		hit_sec_type ? {29'h0, security_info_record_type_reg} : hit_src_size ? src_size_reg :
		hit_src_base ? src_base_reg : hit_src_xfm ? src_xfm_reg :
		hit_src_frame ? src_frame_reg : hit_map_index ? {{(32-AW){1'b0}}, map_index_reg} :
		hit_map_data ? {27'h0, map_rd_data[4:0]} :
		32'h0;

	// one wait state per access
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (clk_en) begin
			pready <= access & ~pready;
			if (access && !pready) begin
				pslverr <= ~hit_any;
				prdata <= pwrite ? 32'h0 : rd_word;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end
endmodule : enclave_leaf_engine

/* File: sim/enclave_leaf_engine_assertions.sv */
// assertions on the apb side of the leaf engine
`timescale 1ns/100ps
module enclave_leaf_engine_assertions import enclave_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	wire acc = psel && penable && !pready;
	wire rd_acc = acc && !pwrite;
	wire mapped = paddr <= ADDR_MAP_DATA && paddr[1:0] == 2'b00;
	// a frozen clock enable holds every answer, so nothing is judged then
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n || !clk_en);
	property p_one_wait; acc |=> pready; endproperty
	a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready held too long");
	property p_err_ready; pslverr |-> pready && $past(psel && penable); endproperty
	a_err_ready: assert property (p_err_ready) else $error("stray slave error");
	property p_unmapped; acc && !mapped && paddr[1:0] == 2'b00 |=> pslverr; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
	property p_mapped; acc && mapped |=> pready && !pslverr; endproperty
	a_mapped: assert property (p_mapped) else $error("mapped access refused");
	property p_write_zero; acc && pwrite |=> prdata == 32'h0; endproperty
	a_write_zero: assert property (p_write_zero) else $error("write returned data");
	property p_err_code; rd_acc && paddr == ADDR_STATUS |=> prdata[31:16] == 16'h0; endproperty
	a_err_code: assert property (p_err_code) else $error("fault code not zero");
	property p_flags; rd_acc && paddr == ADDR_STATUS |=> prdata[7:4] == 4'h0; endproperty
	a_flags: assert property (p_flags) else $error("parity group flag set");
	property p_hidden; rd_acc && paddr == ADDR_MAP_DATA |=> prdata[31:5] == 27'h0; endproperty
	a_hidden: assert property (p_hidden) else $error("entry contents exposed");
endmodule : enclave_leaf_engine_assertions
bind enclave_leaf_engine enclave_leaf_engine_assertions enclave_leaf_engine_assertions_i (
	.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));

/* File: sim/leaf_issuer.sv */
// software side model: apb master issuing leaf operations
`timescale 1ns/100ps
module leaf_issuer import enclave_pkg::*; (
	input wire logic sys_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// no wait bound here: the bench timeout cuts a hang
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask : xfer
	task automatic legal_source(input logic [31:0] size, input logic [31:0] base,
		input logic [31:0] frame, input logic [31:0] xfm);
		logic [31:0] q;
		logic e;
		xfer(1'b1, ADDR_PI_SRC, 32'h0004_1000, q, e);
		xfer(1'b1, ADDR_PI_SECURITY_INFO_RECORD, 32'h0004_2040, q, e);
		xfer(1'b1, ADDR_PI_CTRL, 32'h0, q, e);
		xfer(1'b1, ADDR_PI_LIN, 32'h0, q, e);
		xfer(1'b1, ADDR_SECURITY_INFO_RECORD_TYPE, {29'h0, CONTROL_PAGE_TYPE}, q, e);
		xfer(1'b1, ADDR_SRC_SIZE, size, q, e);
		xfer(1'b1, ADDR_SRC_BASE, base, q, e);
		xfer(1'b1, ADDR_SRC_XFM, xfm, q, e);
		xfer(1'b1, ADDR_SRC_FRAME, frame, q, e);
	endtask : legal_source
endmodule : leaf_issuer

/* File: sim/enclave_page_block_and_create_bench.sv */
// self-checking bench for the enclave page block and create engine
`timescale 1ns/100ps
module enclave_page_block_and_create_bench import enclave_pkg::*;;
	localparam logic [31:0] BASE = 32'h8000_0000;
	logic sys_clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr, e, v, b;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, st, c;
	logic [2:0] t;
	logic [3:0] idx;
	int err_count, checks, cycles, seed, i, k;
	enclave_leaf_engine #(.CACHE_BASE(BASE), .CACHE_PAGES(16), .AW(4)) enclave_leaf_engine_i (
		.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	leaf_issuer leaf_issuer_i (.sys_clk(sys_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task print_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			err_count = err_count + 1;
			print_verdict();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		leaf_issuer_i.xfer(1'b1, a, d, q, e);
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] r);
		leaf_issuer_i.xfer(1'b0, a, 32'h0, r, e);
	endtask : rd
	task put(input logic [3:0] n, input logic [31:0] d);
		wr(ADDR_MAP_INDEX, {28'h0, n});
		wr(ADDR_MAP_DATA, d);
	endtask : put
	task get(input logic [3:0] n);
		wr(ADDR_MAP_INDEX, {28'h0, n});
		rd(ADDR_MAP_DATA, q);
	endtask : get
	task leaf(input logic [31:0] code, input logic [31:0] op3, input logic [31:0] hi,
		input logic [31:0] ctl);
		wr(ADDR_OP3, op3);
		wr(ADDR_OP3_HI, hi);
		wr(ADDR_RESULT, code);
		wr(ADDR_CTRL, ctl | 32'h1);
		st = 32'h1;
		for (k = 0; k < 20 && (st[1] !== 1'b1 || st[0] !== 1'b0); k++) rd(ADDR_STATUS, st);
	endtask : leaf
	function automatic logic [31:0] blk_code(input logic vv, input logic bb, input logic [2:0] tt);
		if (!vv) return PAGE_INVALID_CODE;
		if (tt != THREAD_CONTROL_TYPE && tt != REGULAR_PAGE_TYPE && tt != TRIMMED_PAGE_TYPE)
			return NOT_BLOCKABLE_CODE;
		if (bb) return ALREADY_BLOCKED_CODE;
		return RES_OK;
	endfunction : blk_code
	function automatic logic [31:0] blk_st(input logic [31:0] cc);
		logic [31:0] s;
		s = 32'h2;
		s[ST_ZF] = cc == PAGE_INVALID_CODE || cc == EPOCH_LOCKED_CODE || cc == LOCK_FAIL_CODE;
		s[ST_CF] = cc == NOT_BLOCKABLE_CODE || cc == ALREADY_BLOCKED_CODE;
		return s;
	endfunction : blk_st
	localparam logic [31:0] REG_ENT = {27'h0, REGULAR_PAGE_TYPE, 2'b01};
	task flt(input logic [31:0] op3, input logic [31:0] hi, input logic [31:0] ctl,
		input logic [1:0] x);
		put(5, REG_ENT);
		leaf(LEAF_BLOCK, op3, hi, ctl);
		chk(st[9:8], x);
		get(5);
		chk(q, REG_ENT);
	endtask : flt
	task mk(input logic [31:0] size, input logic [31:0] base, input logic [31:0] xfm,
		input logic [7:0] fa, input logic [31:0] fd, input logic [1:0] x);
		put(9, 32'h0);
		leaf_issuer_i.legal_source(size, base, 32'h1, xfm);
		wr(fa, fd);
		leaf(LEAF_CREATE, BASE + 32'h9000, 32'h0, 32'h0);
		chk(st[9:8], x);
		get(9);
		chk(q, x == 2'b00 ? 32'h1 : 32'h0);
	endtask : mk
	initial begin
		seed = 72297;
		err_count = 0;
		checks = 0;
		cycles = 0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(ADDR_SEG_LIMIT, q);
		chk(q, 32'hFFFF_FFFF);
		rd(ADDR_STATUS, q);
		chk(q, 32'h0);
		leaf_issuer_i.xfer(1'b0, 8'h80, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		for (i = 0; i < 32; i++) begin
			idx = 4'($random(seed));
			{b, v, t} = 5'(i);
			c = blk_code(v, b, t);
			put(idx, {27'h0, t, b, v});
			leaf(LEAF_BLOCK, BASE + {idx, 12'h000}, 32'h0, 32'h0);
			chk(st, blk_st(c));
			rd(ADDR_RESULT, q);
			chk(q, c);
			get(idx);
			chk(q, {27'h0, t, b | (c == RES_OK), v});
		end
		put(3, REG_ENT);
		for (i = 0; i < 2; i++) begin
			leaf(LEAF_BLOCK, BASE + 32'h3000, 32'h0, 32'h8);
			rd(ADDR_RESULT, q);
			chk(q, i ? ALREADY_BLOCKED_CODE : RES_OK);
		end
		for (i = 0; i < 2; i++) begin
			put(5, REG_ENT);
			wr(ADDR_CONC, 32'h1 << i);
			leaf(LEAF_BLOCK, BASE + 32'h5000, 32'h0, 32'h0);
			chk(st, blk_st(i ? LOCK_FAIL_CODE : EPOCH_LOCKED_CODE));
		end
		wr(ADDR_CONC, 32'h4);
		flt(BASE + 32'h5000, 32'h0, 32'h0, 2'b01);
		wr(ADDR_CONC, 32'h8);
		flt(BASE + 32'h5000, 32'h0, 32'h0, 2'b10);
		wr(ADDR_CONC, 32'h0);
		// frozen clock enable mid-leaf: the leaf must still be busy when polled
		put(6, REG_ENT);
		wr(ADDR_OP3, BASE + 32'h6000);
		wr(ADDR_RESULT, LEAF_BLOCK);
		wr(ADDR_CTRL, 32'h1);
		clk_en <= 1'b0;
		repeat (6) @(posedge sys_clk);
		clk_en <= 1'b1;
		rd(ADDR_STATUS, q);
		chk(q[1:0], 2'b01);
		get(6);
		chk(q, REG_ENT | 32'h2);
		flt(BASE + 32'h5000, 32'h0, 32'h2, 2'b01);
		flt(BASE + 32'h5010, 32'h0, 32'h0, 2'b01);
		flt(BASE + 32'h5000, 32'h0000_8000, 32'h8, 2'b01);
		flt(BASE + 32'h1_0000, 32'h0, 32'h0, 2'b10);
		wr(ADDR_SEG_LIMIT, BASE + 32'h4FFF);
		flt(BASE + 32'h5000, 32'h0, 32'h0, 2'b01);
		wr(ADDR_SEG_LIMIT, 32'hFFFF_FFFF);
		k = $random(seed);
		mk(32'h2000, 32'h2000 * (k & 32'hFF), 32'h3, ADDR_PI_LIN, 32'h0, 2'b00);
		leaf(LEAF_CREATE, BASE + 32'h9000, 32'h0, 32'h0);
		chk(st[9:8], 2'b10);
		mk(32'h1000, 32'h0, 32'h3, ADDR_PI_LIN, 32'h0, 2'b01);
		mk(32'h2000, 32'h1000, 32'h3, ADDR_PI_LIN, 32'h0, 2'b01);
		mk(32'h2000, 32'h0, 32'h3, ADDR_PI_CTRL, 32'h1, 2'b01);
		mk(32'h2000, 32'h0, 32'h3, ADDR_SECURITY_INFO_RECORD_TYPE, 32'h2, 2'b01);
		mk(32'h2000, 32'h0, 32'h7FFF, ADDR_PI_LIN, 32'h0, 2'b00);
		mk(32'h2000, 32'h0, 32'hFFFF, ADDR_PI_LIN, 32'h0, 2'b01);
		for (i = 0; i < 4; i++) begin
			c = 32'h3 | ($random(seed) & 32'h0003_FFFC);
			mk(32'h4000, 32'h0, c, ADDR_PI_LIN, 32'h0,
				(GPR_AREA_BYTES + FEATURE_AREA_BYTES * $countones(c)) > 32'h1000);
		end
		mk(32'h2000, 32'h0, 32'h3, ADDR_OP2, 32'h10, 2'b01);
		print_verdict();
	end
endmodule : enclave_page_block_and_create_bench
